// file: verilog/spm_map.svh
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH
// Register offsets (byte addresses of config dwords)
`define SPM_OFS_PM_HDR 8'h40
`define SPM_OFS_PM_CSR 8'h44
`define SPM_OFS_MSI_HDR 8'h4C
// Capability header constants
`define SPM_PM_CAP_ID 8'h01
`define SPM_NEXT_UP 8'h5C
`define SPM_NEXT_DN 8'h4C
`define SPM_PM_REV 3'h3
`define SPM_MSI_CAP_ID 8'h05
`define SPM_MSI_NEXT 8'h64
// Loadable defaults
`define SPM_RST_DSI 1'h0
`define SPM_RST_AUX 3'h7
`define SPM_RST_D1 1'h1
`define SPM_RST_D2 1'h1
`define SPM_RST_PMES 5'h1F
`define SPM_RST_NSR 1'h1
`define SPM_RST_DATA 8'h00
// Control field reset values
`define SPM_RST_PSTATE 2'h0
`define SPM_RST_PMEEN 1'h0
`define SPM_RST_DSEL 4'h0
// Field positions
`define SPM_B_PSTATE_LO 0
`define SPM_B_NSR 3
`define SPM_B_PMEEN 8
`define SPM_B_DSEL_LO 9
`define SPM_B_PMESTS 15
`define SPM_B_DATA_LO 24
`define SPM_B_DSI 21
`define SPM_B_AUX_LO 22
`define SPM_B_D1 25
`define SPM_B_D2 26
`define SPM_B_PMES_LO 27
// Length of internal hot reset pulse, cycles
`define SPM_HOTRST_CYC 4'h4
`endif

// file: verilog/spm_pkg.sv
package spm_pkg;
  typedef enum logic [1:0] {
    SPM_D0 = 2'h0,
    SPM_D1 = 2'h1,
    SPM_D2 = 2'h2,
    SPM_D3HOT = 2'h3
  } spm_pstate_e;

  // Loadable read-only capability fields
  typedef struct packed {
    logic dev_init;
    logic [2:0] aux_cur;
    logic d1_sup;
    logic d2_sup;
    logic [4:0] pme_sup;
    logic no_soft_rst;
    logic [7:0] data;
  } spm_load_s;

  // Configuration access from the port core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } spm_cfg_s;
endpackage : spm_pkg

// file: verilog/spm_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.svh"
module spm_regs #(
  parameter bit UPSTREAM = 1'b0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire spm_pkg::spm_cfg_s cfg_i,
  input wire logic load_i,
  input wire spm_pkg::spm_load_s load_val_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic [1:0] pstate_o,
  output logic pme_en_o,
  output logic hot_reset_o,
  output logic downstream_reset_out_n_o
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  spm_pkg::spm_load_s ld_ff;
  spm_pkg::spm_pstate_e pst_ff;
  logic pmeen_ff;
  logic [3:0] dsel_ff;
  logic [3:0] hr_cnt_ff;
  logic hot_ff;
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic [31:0] nxt_rdata;
  logic csr_wr;
  logic msi_vis;
  logic hr_start;
  logic dn_rst_n_ff;

  assign csr_wr = ce_i && cfg_i.wr && hit(cfg_i.addr, `SPM_OFS_PM_CSR);
  assign msi_vis = !UPSTREAM;
  // D0 written over D3hot with soft reset allowed
  assign hr_start = csr_wr && cfg_i.be[0] && pst_ff == spm_pkg::SPM_D3HOT
                    && cfg_i.wdata[1:0] == spm_pkg::SPM_D0
                    && !ld_ff.no_soft_rst;

  // ------------------------------------------------------------
  // Loadable defaults
  // ------------------------------------------------------------
  // Config writes never reach these; only the load path does
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ld_ff.dev_init <= `SPM_RST_DSI;
      ld_ff.aux_cur <= `SPM_RST_AUX;
      ld_ff.d1_sup <= `SPM_RST_D1;
      ld_ff.d2_sup <= `SPM_RST_D2;
      ld_ff.pme_sup <= `SPM_RST_PMES;
      ld_ff.no_soft_rst <= `SPM_RST_NSR;
      ld_ff.data <= `SPM_RST_DATA;
    end else if (ce_i && load_i) begin
      ld_ff <= load_val_i;
    end
  end

  // ------------------------------------------------------------
  // Power state and PME enable
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pst_ff <= spm_pkg::spm_pstate_e'(`SPM_RST_PSTATE);
    end else if (ce_i && hr_cnt_ff != 4'h0) begin
      pst_ff <= spm_pkg::SPM_D0;
    end else if (csr_wr && cfg_i.be[0]) begin
      pst_ff <= spm_pkg::spm_pstate_e'(cfg_i.wdata[1:0]);
    end
  end

  // Internal reset returns control fields to defaults
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pmeen_ff <= `SPM_RST_PMEEN;
      dsel_ff <= `SPM_RST_DSEL;
    end else if (ce_i && hr_cnt_ff != 4'h0) begin
      pmeen_ff <= `SPM_RST_PMEEN;
      dsel_ff <= `SPM_RST_DSEL;
    end else if (csr_wr && cfg_i.be[1]) begin
      pmeen_ff <= cfg_i.wdata[`SPM_B_PMEEN];
      dsel_ff <= cfg_i.wdata[`SPM_B_DSEL_LO +: 4];
    end
  end

  // ------------------------------------------------------------
  // D3hot to D0 hot reset
  // ------------------------------------------------------------
  // Only fires when no-soft-reset is clear; downstream pin stays high
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hr_cnt_ff <= 4'h0;
    end else if (ce_i) begin
      if (hr_start) begin
        hr_cnt_ff <= `SPM_HOTRST_CYC;
      end else if (hr_cnt_ff != 4'h0) begin
        hr_cnt_ff <= hr_cnt_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hot_ff <= 1'b0;
    end else if (ce_i) begin
      hot_ff <= (hr_cnt_ff != 4'h0);
    end
  end

  // ------------------------------------------------------------
  // Downstream reset pin
  // ------------------------------------------------------------
  // Hot reset of this port never reaches the pin, so it idles high
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dn_rst_n_ff <= 1'b1;
    end else if (ce_i) begin
      dn_rst_n_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0;
    if (hit(cfg_i.addr, `SPM_OFS_PM_HDR)) begin
      nxt_rdata[7:0] = `SPM_PM_CAP_ID;
      nxt_rdata[15:8] = UPSTREAM ? `SPM_NEXT_UP : `SPM_NEXT_DN;
      nxt_rdata[18:16] = `SPM_PM_REV;
      nxt_rdata[`SPM_B_DSI] = ld_ff.dev_init;
      nxt_rdata[`SPM_B_AUX_LO +: 3] = ld_ff.aux_cur;
      nxt_rdata[`SPM_B_D1] = ld_ff.d1_sup;
      nxt_rdata[`SPM_B_D2] = ld_ff.d2_sup;
      nxt_rdata[`SPM_B_PMES_LO +: 5] = ld_ff.pme_sup;
    end else if (hit(cfg_i.addr, `SPM_OFS_PM_CSR)) begin
      nxt_rdata[1:0] = pst_ff;
      nxt_rdata[`SPM_B_NSR] = ld_ff.no_soft_rst;
      nxt_rdata[`SPM_B_PMEEN] = pmeen_ff;
      nxt_rdata[`SPM_B_DSEL_LO +: 4] = dsel_ff;
      nxt_rdata[`SPM_B_PMESTS] = 1'b0;
      nxt_rdata[`SPM_B_DATA_LO +: 8] = ld_ff.data;
    end else if (msi_vis && hit(cfg_i.addr, `SPM_OFS_MSI_HDR)) begin
      nxt_rdata[7:0] = `SPM_MSI_CAP_ID;
      nxt_rdata[15:8] = `SPM_MSI_NEXT;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 32'h0;
      rvalid_ff <= 1'b0;
    end else if (ce_i) begin
      rvalid_ff <= cfg_i.rd;
      if (cfg_i.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign rdata_o = rdata_ff;
  assign rvalid_o = rvalid_ff;
  assign pstate_o = pst_ff;
  assign pme_en_o = pmeen_ff;
  assign hot_reset_o = hot_ff;
  assign downstream_reset_out_n_o = dn_rst_n_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_cap_id_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && hit(cfg_i.addr, `SPM_OFS_PM_HDR)
    |=> rdata_o[7:0] == 8'h01) else $error("bad pm cap id");
  a_next_ptr_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && hit(cfg_i.addr, `SPM_OFS_PM_HDR)
    |=> rdata_o[15:8] == (UPSTREAM ? 8'h5C : 8'h4C))
    else $error("bad next pointer");
  a_pm_rev_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && hit(cfg_i.addr, `SPM_OFS_PM_HDR)
    |=> rdata_o[18:16] == 3'h3 && rdata_o[20:19] == 2'h0)
    else $error("bad pm revision");
  a_pstate_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    csr_wr && cfg_i.be[0] && hr_cnt_ff == 4'h0
    |=> pstate_o == $past(cfg_i.wdata[1:0]))
    else $error("power state not written");
  a_hot_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
    csr_wr && cfg_i.be[0] && pst_ff == spm_pkg::SPM_D3HOT
    && cfg_i.wdata[1:0] == 2'h0 && !ld_ff.no_soft_rst
    |=> ##1 hot_reset_o) else $error("no hot reset");
  a_no_soft_rst: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ld_ff.no_soft_rst && hr_cnt_ff == 4'h0 |=> !hot_reset_o)
    else $error("reset with no-soft-reset set");
  a_pme_stat_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rvalid_o |-> !rdata_o[15] || !$past(hit(cfg_i.addr, `SPM_OFS_PM_CSR)))
    else $error("pme status set");
  a_msi_hdr_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && !UPSTREAM && hit(cfg_i.addr, `SPM_OFS_MSI_HDR)
    |=> rdata_o[15:0] == 16'h6405) else $error("bad msi header");
  a_dn_rst_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    downstream_reset_out_n_o)
    else $error("downstream reset asserted");

  // ------------------------------------------------------------
  // Header and status field checks
  // ------------------------------------------------------------
  // Loadable fields must show whatever was loaded last
  a_hdr_fields: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && hit(cfg_i.addr, `SPM_OFS_PM_HDR)
    |=> rdata_o[31:21] == $past({ld_ff.pme_sup, ld_ff.d2_sup,
        ld_ff.d1_sup, ld_ff.aux_cur, ld_ff.dev_init}))
    else $error("bad header fields");
  a_csr_rsvd: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && hit(cfg_i.addr, `SPM_OFS_PM_CSR)
    |=> rdata_o[2] == 1'b0 && rdata_o[7:4] == 4'h0
        && rdata_o[23:13] == 11'h0)
    else $error("reserved bits set");
  a_csr_nsr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && hit(cfg_i.addr, `SPM_OFS_PM_CSR)
    |=> rdata_o[3] == $past(ld_ff.no_soft_rst))
    else $error("bad no soft reset bit");
  a_data_byte: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && hit(cfg_i.addr, `SPM_OFS_PM_CSR)
    |=> rdata_o[31:24] == $past(ld_ff.data))
    else $error("bad data byte");
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && !hit(cfg_i.addr, `SPM_OFS_PM_HDR)
    && !hit(cfg_i.addr, `SPM_OFS_PM_CSR)
    && !hit(cfg_i.addr, `SPM_OFS_MSI_HDR)
    |=> rdata_o == 32'h0) else $error("unmapped read not zero");
  a_msi_hidden: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd && UPSTREAM && hit(cfg_i.addr, `SPM_OFS_MSI_HDR)
    |=> rdata_o == 32'h0) else $error("msi header on upstream");

  // ------------------------------------------------------------
  // Read handshake checks
  // ------------------------------------------------------------
  // Software may poll back to back, so rvalid must follow rd one enabled cycle later
  a_rvalid_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && cfg_i.rd |=> rvalid_o)
    else $error("read not answered");
  a_rvalid_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && !cfg_i.rd |=> !rvalid_o)
    else $error("spurious read answer");
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(ce_i && cfg_i.rd) |=> $stable(rdata_o))
    else $error("read data moved");

  // ------------------------------------------------------------
  // Control and loadable field checks
  // ------------------------------------------------------------
  a_pme_en_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    csr_wr && cfg_i.be[1] && hr_cnt_ff == 4'h0
    |=> pme_en_o == $past(cfg_i.wdata[`SPM_B_PMEEN]))
    else $error("pme enable not written");
  a_pme_en_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(csr_wr && cfg_i.be[1]) && hr_cnt_ff == 4'h0
    |=> $stable(pme_en_o)) else $error("pme enable moved");
  a_pst_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(csr_wr && cfg_i.be[0]) && hr_cnt_ff == 4'h0
    |=> $stable(pstate_o)) else $error("power state moved");
  a_ld_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(ce_i && load_i) |=> ld_ff == $past(ld_ff))
    else $error("loadable field changed");
  a_load_fields: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && load_i |=> ld_ff == $past(load_val_i))
    else $error("load not taken");

  // ------------------------------------------------------------
  // Hot reset checks
  // ------------------------------------------------------------
  // Counter length sets how long the port sits in internal reset
  a_hr_reload: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && hr_start |=> hr_cnt_ff == `SPM_HOTRST_CYC)
    else $error("hot reset not started");
  a_hr_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && !hr_start && hr_cnt_ff != 4'h0
    |=> hr_cnt_ff == $past(hr_cnt_ff) - 4'h1)
    else $error("hot reset count wrong");
  a_hot_forced_d0: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && hr_cnt_ff != 4'h0 |=> pstate_o == 2'h0 && !pme_en_o)
    else $error("state not reset");
  a_hr_needs_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    hr_start |-> !ld_ff.no_soft_rst)
    else $error("soft reset while barred");

  // ------------------------------------------------------------
  // Clock enable checks
  // ------------------------------------------------------------
  // A frozen block must not move any visible state
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ce_i |=> $stable(pstate_o) && $stable(pme_en_o)
    && $stable(hot_reset_o) && $stable(rvalid_o) && $stable(rdata_o))
    else $error("state moved while frozen");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  c_d3_entry: cover property (@(posedge clk_i) pstate_o == 2'h3);
  c_hot_reset: cover property (@(posedge clk_i) $rose(hot_reset_o));
  c_load: cover property (@(posedge clk_i) ce_i && load_i);
  c_frozen_write: cover property (@(posedge clk_i) !ce_i && cfg_i.wr);
endmodule : spm_regs
`default_nettype wire

// file: tb/spm_host.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// Configuration software issuing single accesses
// ------------------------------------------------
module spm_host (
  input wire logic clk_i,
  output spm_pkg::spm_cfg_s cfg_o
);
  initial cfg_o = '0;

  // One request per call, launched and dropped off the sampling edge
  task automatic acc(input logic r, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(negedge clk_i);
    cfg_o <= '{rd: r, wr: !r, addr: a, be: b, wdata: d};
    @(negedge clk_i);
    cfg_o.rd <= 1'b0;
    cfg_o.wr <= 1'b0;
  endtask : acc
endmodule : spm_host
`default_nettype wire

// file: tb/spm_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module spm_regs_test;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic load_i = 1'b0;
  logic ce = 1'b1;
  spm_pkg::spm_load_s lv;
  spm_pkg::spm_cfg_s cfg;
  logic [31:0] rdata;
  logic [31:0] w;
  logic [3:0] b;
  logic [1:0] pstate;
  logic rvalid;
  logic pme_en;
  logic hot_reset;
  logic dn_n;
  integer err_count = 0;
  integer checks = 0;
  integer seed = 32'hA457;
  integer n;
  integer k;
  integer ps;
  integer pme;
  integer dsel;

  initial forever #25 clk_i = ~clk_i;

  spm_host spm_host_inst (.clk_i(clk_i), .cfg_o(cfg));
  spm_regs spm_regs_inst (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .cfg_i(cfg), .load_i(load_i), .load_val_i(lv), .rdata_o(rdata),
    .rvalid_o(rvalid), .pstate_o(pstate), .pme_en_o(pme_en),
    .hot_reset_o(hot_reset), .downstream_reset_out_n_o(dn_n));

  // ------------------------------------------------
  // Model and checking helpers
  // ------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] hdr();
    return {lv.pme_sup, lv.d2_sup, lv.d1_sup, lv.aux_cur, lv.dev_init,
            2'h0, 3'h3, 8'h4C, 8'h01};
  endfunction : hdr

  function automatic logic [31:0] csr();
    return {lv.data, 8'h00, 3'h0, dsel[3:0], pme[0], 4'h0,
            lv.no_soft_rst, 1'b0, ps[1:0]};
  endfunction : csr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    spm_host_inst.acc(1'b1, a, 4'hF, 32'h0);
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask : rd

  task automatic give_verdict();
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    #300000;
    err_count++;
    give_verdict();
  end

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    lv = '{dev_init: 1'b0, aux_cur: 3'h7, d1_sup: 1'b1, d2_sup: 1'b1,
           pme_sup: 5'h1F, no_soft_rst: 1'b1, data: 8'h00};
    ps = 0;
    pme = 0;
    dsel = 0;
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    rd(8'h40, hdr());
    rd(8'h44, csr());
    rd(8'h4C, 32'h0000_6405);
    rd(8'h80, 32'h0);
    for (n = 0; n < 8; n++) begin
      spm_host_inst.acc(1'b0, 8'h40, 4'hF, $random(seed));
      spm_host_inst.acc(1'b0, 8'h4C, 4'hF, $random(seed));
      w = $random(seed);
      b = $random(seed);
      spm_host_inst.acc(1'b0, 8'h44, b, w);
      if (b[0]) ps = w[1:0];
      if (b[1]) begin
        pme = w[8];
        dsel = w[12:9];
      end
      rd(8'h40, hdr());
      rd(8'h4C, 32'h0000_6405);
      rd(8'h44, csr());
      chk({30'h0, pstate}, ps);
      chk({31'h0, pme_en}, pme);
      chk({31'h0, hot_reset}, 32'h0);
    end
    // Frozen block must ignore a write
    ce = 1'b0;
    spm_host_inst.acc(1'b0, 8'h44, 4'h1, {30'h0, ~ps[1:0]});
    chk({30'h0, pstate}, ps);
    ce = 1'b1;
    // Fresh loadable defaults, soft reset now allowed
    @(negedge clk_i);
    w = $random(seed);
    lv = w[19:0];
    lv.no_soft_rst = 1'b0;
    load_i = 1'b1;
    @(negedge clk_i);
    load_i = 1'b0;
    rd(8'h40, hdr());
    spm_host_inst.acc(1'b0, 8'h44, 4'h3, 32'h0000_0103);
    ps = 3;
    pme = 1;
    dsel = 0;
    rd(8'h44, csr());
    spm_host_inst.acc(1'b0, 8'h44, 4'h1, 32'h0);
    k = 0;
    repeat (10) begin
      @(negedge clk_i);
      k = k + hot_reset;
      chk({31'h0, dn_n}, 32'h1);
    end
    chk(k, 32'h4);
    ps = 0;
    pme = 0;
    rd(8'h44, csr());
    give_verdict();
  end
endmodule : spm_regs_test
`default_nettype wire
